// File: logic/front_panel_target_keypad.sv
// Purpose: front panel keypad decoder, target LEDs and clear-key sequences
// Assumes: keys are raw pins; element flags come from logic on clk
// Notes: registers over Avalon-MM, one wait cycle per access
//
// Behaviour
// - no targets: one press prompts alarm reset, then seal-in reset, 5 s each
// - no targets: two presses in one window start demand scrolling
// - no targets: three presses prompt min/max reset, next press does it
// - targets lit: first press only prompts to clear fault data
// - second press within 5 s clears fault data, prompts target clear
// - third press within 5 s clears targets, prompts output release
// - fourth press after output prompt releases sealed-in outputs
// - clear, enter and up together issue a system reset pulse
// - held arrow steps slowly; separate presses step at once, faster
// - latched targets hold until clear sequence, reset button or, in last mode, the next trip
// - last mode replaces targets per trip; accumulate mode ORs them
// - non-latched LEDs follow their condition exactly
// - health LED on normally; failure turns it off, fail LED on
// - health LED flashes while any logical point is forced
// - self-check alarm contact follows the fail LED
// - pickup LED lit while any overcurrent element is picked up
// - recloser-out LED lit when enable low or first step is lockout
// - phase and neutral LEDs latch on a trip involving them
// - time overcurrent trips set the latched time target
// - any instantaneous level trip sets the latched instant target
// - negative-sequence time trip also sets its latched target
// - while reclosing with no clear-key sequence in progress, display shows remaining interval counting down
`timescale 1ns/100ps
module front_panel_target_keypad
	import panel_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYCLES_DEF,
	parameter int FLASH_CYCLES = FLASH_CYCLES_DEF,
	parameter int REPEAT_CYCLES = REPEAT_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire keys_type keys_n,
	input wire elements_type pickup,
	input wire elements_type trip,
	input wire fault_type fault,
	input wire logic recloser_enable_input,
	input wire logic reclose_step1_lockout,
	input wire logic reclose_active,
	input wire logic [15:0] reclose_remaining,
	input wire logic self_test_fail,
	input wire logic forced_io,
	output leds_type leds,
	output logic self_check_alarm,
	output actions_type actions,
	output logic demand_scroll,
	output screen_type screen,
	output logic [15:0] countdown
);

	typedef struct packed {
		keys_type sync1;
		keys_type sync2;
		keys_type prev;
		logic combo_prev;
		seq_state_type seq;
		logic [1:0] press_cnt;
		logic [31:0] win_cnt;
		logic [31:0] flash_cnt;
		logic flash;
		logic [31:0] rep_cnt;
		logic trip_prev;
		latched_type latched;
		logic accumulate;
		leds_type leds;
		logic alarm;
		actions_type actions;
		logic scroll;
		screen_type screen;
		logic [15:0] countdown;
		logic waitrequest;
		logic [31:0] readdata;
	} state_type;

	state_type q;
	state_type d;

	keys_type rise;
	logic combo;
	logic press;
	logic expired;
	logic targets_lit;
	logic clear_targets;
	logic trip_any;
	logic arrow_held;
	latched_type fresh;
	logic [31:0] rd;

	always_comb begin
		d = q;
		d.actions = '0;

		// two-flop synchroniser; keys are active low at the pins
		d.sync1 = ~keys_n;
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		rise = q.sync2 & ~q.prev;

		combo = q.sync2.clear & q.sync2.enter & q.sync2.up;
		d.combo_prev = combo;
		d.actions.system_reset = combo & ~q.combo_prev;
		press = rise.clear & ~combo;

		targets_lit = |q.latched;
		expired = (q.win_cnt == 32'h0000_0000);
		if (!expired) begin
			d.win_cnt = q.win_cnt - 32'h0000_0001;
		end
		clear_targets = q.sync2.target_reset;

		unique case (q.seq)
			SEQ_IDLE: begin
				if (press) begin
					d.win_cnt = 32'(WINDOW_CYCLES);
					d.press_cnt = 2'h1;
					d.seq = targets_lit ? SEQ_FAULT : SEQ_COUNT;
				end
			end
			SEQ_COUNT: begin
				if (press && q.press_cnt != 2'h3) begin
					d.press_cnt = q.press_cnt + 2'h1;
				end else if (expired) begin
					d.win_cnt = 32'(WINDOW_CYCLES);
					unique case (q.press_cnt)
						2'h1: d.seq = SEQ_ALARM;
						2'h2: d.seq = SEQ_SCROLL;
						default: d.seq = SEQ_MINMAX;
					endcase
				end
			end
			SEQ_ALARM: begin
				if (press) begin
					d.actions.alarm_reset = 1'b1;
					d.win_cnt = 32'(WINDOW_CYCLES);
					d.seq = SEQ_SEAL;
				end else if (expired) begin
					d.seq = SEQ_IDLE;
				end
			end
			SEQ_SEAL: begin
				if (press) begin
					d.actions.seal_in_reset = 1'b1;
					d.seq = SEQ_IDLE;
				end else if (expired) begin
					d.seq = SEQ_IDLE;
				end
			end
			SEQ_MINMAX: begin
				if (press) begin
					d.actions.minmax_reset = 1'b1;
					d.seq = SEQ_IDLE;
				end else if (expired) begin
					d.seq = SEQ_IDLE;
				end
			end
			SEQ_SCROLL: begin
				// scrolling runs until the next clear press
				if (press) begin
					d.seq = SEQ_IDLE;
				end
			end
			SEQ_FAULT: begin
				if (press && !expired) begin
					d.actions.fault_data_clear = 1'b1;
					d.win_cnt = 32'(WINDOW_CYCLES);
					d.seq = SEQ_TARGET;
				end else if (expired) begin
					d.seq = SEQ_IDLE;
				end
			end
			SEQ_TARGET: begin
				if (press && !expired) begin
					clear_targets = 1'b1;
					d.seq = SEQ_OUTPUT;
				end else if (expired) begin
					d.seq = SEQ_IDLE;
				end
			end
			SEQ_OUTPUT: begin
				// no window: waits for the releasing press
				if (press) begin
					d.actions.seal_in_reset = 1'b1;
					d.seq = SEQ_IDLE;
				end
			end
		endcase
		d.scroll = (d.seq == SEQ_SCROLL);

		// arrow stepping: press steps at once, hold repeats slowly
		arrow_held = q.sync2.left | q.sync2.right;
		if (rise.left || rise.right) begin
			d.actions.value_step = 1'b1;
			d.actions.step_up = rise.right;
			d.rep_cnt = 32'(REPEAT_CYCLES);
		end else if (arrow_held) begin
			if (q.rep_cnt == 32'h0000_0000) begin
				d.actions.value_step = 1'b1;
				d.actions.step_up = q.sync2.right;
				d.rep_cnt = 32'(REPEAT_CYCLES);
			end else begin
				d.rep_cnt = q.rep_cnt - 32'h0000_0001;
			end
		end else begin
			d.rep_cnt = 32'h0000_0000;
		end

		// latched targets; a trip in the clearing cycle still sets them
		trip_any = |trip;
		d.trip_prev = trip_any;
		fresh.phase_a = fault.phase_a;
		fresh.phase_b = fault.phase_b;
		fresh.phase_c = fault.phase_c;
		fresh.neutral = fault.neutral;
		fresh.time_trip = trip.phase_time_overcurrent |
			trip.ground_time_overcurrent |
			trip.negative_sequence_time;
		fresh.instant_trip = trip.phase_instant_level_low |
			trip.phase_instant_level_mid |
			trip.phase_instant_level_high |
			trip.ground_instant_level_low |
			trip.ground_instant_level_mid |
			trip.ground_instant_level_high;
		fresh.negseq_trip = trip.negative_sequence_time;
		if (clear_targets) begin
			d.latched = '0;
		end
		if (trip_any && !q.trip_prev && !q.accumulate) begin
			d.latched = '0;
		end
		if (trip_any) begin
			d.latched = d.latched | fresh;
		end

		// health flash timebase
		if (q.flash_cnt == 32'h0000_0000) begin
			d.flash_cnt = 32'(FLASH_CYCLES - 1);
			d.flash = ~q.flash;
		end else begin
			d.flash_cnt = q.flash_cnt - 32'h0000_0001;
		end

		d.leds.spare = 1'b0;
		d.leds.fail = self_test_fail;
		d.leds.normal = ~self_test_fail & (~forced_io | q.flash);
		d.leds.pickup = |pickup;
		d.leds.recloser_out = ~recloser_enable_input |
			reclose_step1_lockout;
		d.leds.latched = d.latched;
		d.alarm = self_test_fail;

		unique case (d.seq)
			SEQ_COUNT: d.screen = SCR_COUNTING;
			SEQ_ALARM: d.screen = SCR_ALARM_PROMPT;
			SEQ_SEAL: d.screen = SCR_SEAL_PROMPT;
			SEQ_MINMAX: d.screen = SCR_MINMAX_PROMPT;
			SEQ_SCROLL: d.screen = SCR_DEMAND_SCROLL;
			SEQ_FAULT: d.screen = SCR_FAULT_PROMPT;
			SEQ_TARGET: d.screen = SCR_TARGET_PROMPT;
			SEQ_OUTPUT: d.screen = SCR_OUTPUT_PROMPT;
			default: begin
				d.screen = reclose_active ? SCR_RECLOSE : SCR_DEFAULT;
			end
		endcase
		d.countdown = reclose_active ? reclose_remaining : 16'h0000;

		// register read mux
		rd = 32'h0000_0000;
		unique case (address)
			REG_CTRL: rd[CTRL_ACCUM_BIT] = q.accumulate;
			REG_STATUS: begin
				rd[STAT_LED_LSB +: 12] = q.leds;
				rd[STAT_FAIL_BIT] = self_test_fail;
				rd[STAT_FORCED_BIT] = forced_io;
				rd[STAT_TARGETS_BIT] = targets_lit;
			end
			REG_SEQ: begin
				rd[SEQ_STATE_LSB +: 9] = q.seq;
				rd[SEQ_CNT_LSB +: 2] = q.press_cnt;
				rd[SEQ_SCREEN_LSB +: 4] = q.screen;
			end
			default: rd = 32'h0000_0000;
		endcase

		// one wait cycle; writes commit while waitrequest is low
		d.waitrequest = 1'b1;
		if ((read || write) && q.waitrequest) begin
			d.waitrequest = 1'b0;
			if (read) begin
				d.readdata = rd;
			end
		end
		if (write && !q.waitrequest && address == REG_CTRL && byteenable[0]) begin
			d.accumulate = writedata[CTRL_ACCUM_BIT];
		end

		if (!resetn) begin
			d = '0;
			d.seq = SEQ_IDLE;
			d.screen = SCR_DEFAULT;
			d.accumulate = CTRL_ACCUM_RESET;
			d.waitrequest = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	assign readdata = q.readdata;
	assign waitrequest = q.waitrequest;
	assign leds = q.leds;
	assign self_check_alarm = q.alarm;
	assign actions = q.actions;
	assign demand_scroll = q.scroll;
	assign screen = q.screen;
	assign countdown = q.countdown;

endmodule : front_panel_target_keypad

// File: logic/panel_pkg.sv
// Purpose: shared constants and types of the front panel controller
// Assumes: 100 MHz system clock
// Notes: register offsets are byte addresses of aligned 32-bit words
package panel_pkg;

	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int WINDOW_S = 5;
	localparam int WINDOW_CYCLES_DEF = WINDOW_S * CLK_HZ;
	localparam int FLASH_HALF_MS = 500;
	localparam int REPEAT_MS = 400;

	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_STATUS = 6'h04;
	localparam logic [5:0] REG_SEQ = 6'h08;

	localparam int CTRL_ACCUM_BIT = 0;
	localparam logic CTRL_ACCUM_RESET = 1'h0;
	localparam int STAT_LED_LSB = 0;
	localparam int STAT_FAIL_BIT = 12;
	localparam int STAT_FORCED_BIT = 13;
	localparam int STAT_TARGETS_BIT = 14;
	localparam int SEQ_STATE_LSB = 0;
	localparam int SEQ_CNT_LSB = 9;
	localparam int SEQ_SCREEN_LSB = 12;

	function automatic int ms_to_cycles(input int ms);
		return ms * CLK_KHZ;
	endfunction : ms_to_cycles

	localparam int FLASH_CYCLES_DEF = ms_to_cycles(FLASH_HALF_MS);
	localparam int REPEAT_CYCLES_DEF = ms_to_cycles(REPEAT_MS);

	typedef struct packed {
		logic clear;
		logic enter;
		logic up;
		logic down;
		logic left;
		logic right;
		logic target_reset;
	} keys_type;

	typedef struct packed {
		logic phase_time_overcurrent;
		logic ground_time_overcurrent;
		logic negative_sequence_time;
		logic phase_instant_level_low;
		logic phase_instant_level_mid;
		logic phase_instant_level_high;
		logic ground_instant_level_low;
		logic ground_instant_level_mid;
		logic ground_instant_level_high;
	} elements_type;

	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic phase_c;
		logic neutral;
	} fault_type;

	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic phase_c;
		logic neutral;
		logic time_trip;
		logic instant_trip;
		logic negseq_trip;
	} latched_type;

	typedef struct packed {
		logic spare;
		logic normal;
		logic fail;
		logic pickup;
		logic recloser_out;
		latched_type latched;
	} leds_type;

	typedef struct packed {
		logic alarm_reset;
		logic seal_in_reset;
		logic fault_data_clear;
		logic minmax_reset;
		logic system_reset;
		logic value_step;
		logic step_up;
	} actions_type;

	typedef enum logic [8:0] {
		SEQ_IDLE = 9'h001,
		SEQ_COUNT = 9'h002,
		SEQ_ALARM = 9'h004,
		SEQ_SEAL = 9'h008,
		SEQ_MINMAX = 9'h010,
		SEQ_SCROLL = 9'h020,
		SEQ_FAULT = 9'h040,
		SEQ_TARGET = 9'h080,
		SEQ_OUTPUT = 9'h100
	} seq_state_type;

	typedef enum logic [3:0] {
		SCR_DEFAULT = 4'h0,
		SCR_COUNTING = 4'h1,
		SCR_ALARM_PROMPT = 4'h2,
		SCR_SEAL_PROMPT = 4'h3,
		SCR_MINMAX_PROMPT = 4'h4,
		SCR_DEMAND_SCROLL = 4'h5,
		SCR_FAULT_PROMPT = 4'h6,
		SCR_TARGET_PROMPT = 4'h7,
		SCR_OUTPUT_PROMPT = 4'h8,
		SCR_RECLOSE = 4'h9
	} screen_type;

endpackage : panel_pkg

// File: test/front_panel_target_keypad_tb_top.sv
// Purpose: self-checking bench of the front panel block
// Assumes: short windows set by parameters
// Notes: expected values worked out by hand
`timescale 1ns/100ps
module front_panel_target_keypad_tb_top
	import panel_pkg::*;
;
	logic clk, resetn, read, write, waitrequest;
	logic [5:0] address;
	logic [31:0] writedata, readdata, rd;
	keys_type keys_n;
	elements_type pickup, trip;
	fault_type fault;
	logic ren, lockout, ractive, fail_in, forced, demand_scroll, alarm;
	logic [15:0] remaining, countdown;
	leds_type leds;
	actions_type actions, act_log;
	screen_type screen;
	int bad_count, checked, cycles, act_n, n0;
	logic [1:0] seen;

	front_panel_target_keypad #(.WINDOW_CYCLES(50), .FLASH_CYCLES(8),
		.REPEAT_CYCLES(10)) i_front_panel_target_keypad (.clk, .resetn,
		.address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
		.waitrequest, .keys_n, .pickup, .trip, .fault,
		.recloser_enable_input(ren), .reclose_step1_lockout(lockout),
		.reclose_active(ractive), .reclose_remaining(remaining),
		.self_test_fail(fail_in), .forced_io(forced), .leds,
		.self_check_alarm(alarm), .actions, .demand_scroll, .screen,
		.countdown);
	keypad_operator i_keypad_operator (.clk, .keys_n);

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (actions !== '0) begin
			act_log <= actions;
			act_n <= act_n + 1;
		end
		if (cycles == 6000) begin
			bad_count++;
			conclude();
		end
	end

	task conclude();
		if (bad_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		@(posedge clk);
		while (waitrequest) @(posedge clk);
		rd = readdata;
		read <= 0;
		write <= 0;
		@(posedge clk);
	endtask : bus

	task rd_chk(input logic [5:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(rd, e);
	endtask : rd_chk

	task hit(input logic [6:0] k, input logic [6:0] ea, input logic [3:0] es);
		n0 = act_n;
		i_keypad_operator.press(k, 4);
		chk(act_n - n0, ea != 0);
		if (ea != 0) chk(act_log, ea);
		if (es != 4'hF) chk(screen, es);
	endtask : hit

	task shot(input logic [8:0] t, input logic [3:0] f);
		trip <= t;
		fault <= f;
		@(posedge clk);
		trip <= '0;
		fault <= '0;
		repeat (3) @(posedge clk);
	endtask : shot

	initial begin
		resetn = 0;
		{read, write, address, writedata, pickup, trip, fault} = '0;
		{lockout, ractive, remaining, fail_in, forced} = '0;
		ren = 1;
		repeat (3) @(posedge clk);
		resetn <= 1;
		repeat (3) @(posedge clk);
		rd_chk(REG_CTRL, 0);
		rd_chk(REG_STATUS, 32'h0000_0400);
		rd_chk(6'h0C, 0);
		shot(9'h140, 4'h8);
		chk(leds.latched, 7'h45);
		bus(1, REG_CTRL, 1);
		rd_chk(REG_CTRL, 1);
		shot(9'h020, 4'h4);
		chk(leds.latched, 7'h67);
		bus(1, REG_CTRL, 0);
		shot(9'h080, 4'h1);
		chk(leds.latched, 7'h0C);
		rd_chk(REG_STATUS, 32'h0000_440C);
		hit(7'h40, 0, SCR_FAULT_PROMPT);
		hit(7'h40, 7'h10, SCR_TARGET_PROMPT);
		hit(7'h40, 0, SCR_OUTPUT_PROMPT);
		chk(leds.latched, 0);
		hit(7'h40, 7'h20, SCR_DEFAULT);
		shot(9'h140, 4'h2);
		hit(7'h01, 0, 4'hF);
		chk(leds.latched, 0);
		hit(7'h40, 0, SCR_COUNTING);
		repeat (50) @(posedge clk);
		chk(screen, SCR_ALARM_PROMPT);
		hit(7'h40, 7'h40, SCR_SEAL_PROMPT);
		hit(7'h40, 7'h20, SCR_DEFAULT);
		repeat (2) hit(7'h40, 0, SCR_COUNTING);
		repeat (50) @(posedge clk);
		chk(screen, SCR_DEMAND_SCROLL);
		chk(demand_scroll, 1);
		hit(7'h40, 0, 4'hF);
		chk(demand_scroll, 0);
		repeat (120) @(posedge clk);
		repeat (3) hit(7'h40, 0, SCR_COUNTING);
		repeat (50) @(posedge clk);
		chk(screen, SCR_MINMAX_PROMPT);
		hit(7'h40, 7'h08, 4'hF);
		hit(7'h40, 0, SCR_COUNTING);
		repeat (50) @(posedge clk);
		chk(screen, SCR_ALARM_PROMPT);
		repeat (60) @(posedge clk);
		chk(screen, SCR_DEFAULT);
		chk(act_n, n0);
		hit(7'h70, 7'h04, 4'hF);
		hit(7'h02, 7'h03, 4'hF);
		hit(7'h04, 7'h02, 4'hF);
		n0 = act_n;
		i_keypad_operator.press(7'h02, 20);
		chk(act_n - n0, 2);
		pickup <= 9'h001;
		ren <= 0;
		fail_in <= 1;
		forced <= 1;
		repeat (3) @(posedge clk);
		chk(leds[11:7], 5'h07);
		chk(alarm, 1);
		rd_chk(REG_STATUS, 32'h0000_3380);
		pickup <= '0;
		{ren, lockout} <= 2'b11;
		{fail_in, forced} <= 2'b00;
		repeat (3) @(posedge clk);
		chk(leds[11:7], 5'h09);
		{lockout, forced} <= 2'b01;
		seen = '0;
		repeat (20) begin
			@(posedge clk);
			seen[leds.normal] = 1'b1;
		end
		chk(seen, 2'b11);
		forced <= 0;
		ractive <= 1;
		remaining <= 16'h0123;
		repeat (3) @(posedge clk);
		chk(countdown, 16'h0123);
		chk(screen, SCR_RECLOSE);
		conclude();
	end
endmodule : front_panel_target_keypad_tb_top

// File: test/keypad_operator.sv
// Purpose: operator at the front keypad
// Assumes: key pins idle high, pressed low
// Notes: press holds the keys for a given number of cycles
`timescale 1ns/100ps
module keypad_operator
	import panel_pkg::*;
(
	input wire logic clk,
	output keys_type keys_n
);
	initial keys_n = '1;

	task press(input logic [6:0] mask, input int hold);
		keys_n <= keys_type'(~mask);
		repeat (hold) @(posedge clk);
		keys_n <= '1;
		repeat (4) @(posedge clk);
	endtask : press
endmodule : keypad_operator

// File: test/panel_checker.sv
// Purpose: port assertions of the front panel block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design top
`timescale 1ns/100ps
module panel_checker
	import panel_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire keys_type keys_n,
	input wire elements_type pickup,
	input wire elements_type trip,
	input wire logic recloser_enable_input,
	input wire logic reclose_step1_lockout,
	input wire logic self_test_fail,
	input wire leds_type leds,
	input wire logic self_check_alarm,
	input wire actions_type actions
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [1:0] run_q;

	// two edges out of reset before lag checks
	always_ff @(posedge clk) begin
		run_q <= resetn ? {run_q[0], 1'b1} : 2'b00;
	end

	alarm_follow_a: assert property (self_check_alarm == leds.fail)
		else $error("alarm contact differs from fail led");
	health_fail_a: assert property (leds.fail |-> !leds.normal)
		else $error("health led lit with fail led");
	fail_led_a: assert property (run_q[1] |->
		leds.fail == $past(self_test_fail)) else $error("fail led wrong");
	pickup_led_a: assert property (run_q[1] |->
		leds.pickup == |$past(pickup)) else $error("pickup led wrong");
	recl_out_a: assert property (run_q[1] |-> leds.recloser_out ==
		($past(reclose_step1_lockout) || !$past(recloser_enable_input)))
		else $error("recloser out led wrong");
	time_latch_a: assert property (run_q[1] && |trip[8:6] |=>
		leds.latched.time_trip) else $error("time target not set");
	inst_latch_a: assert property (run_q[1] && |trip[5:0] |=>
		leds.latched.instant_trip) else $error("instant target not set");
	negseq_latch_a: assert property (run_q[1] && trip[6] |=>
		leds.latched.negseq_trip) else $error("negseq target not set");
	sys_reset_a: assert property (actions.system_reset |->
		!$past(keys_n.clear, 2) && !$past(keys_n.enter, 2) &&
		!$past(keys_n.up, 2)) else $error("system reset without keys");
endmodule : panel_checker

bind front_panel_target_keypad panel_checker i_panel_checker (.clk,
	.resetn, .keys_n, .pickup, .trip, .recloser_enable_input,
	.reclose_step1_lockout, .self_test_fail, .leds, .self_check_alarm,
	.actions);
